// File: logic/hbf_pkg.sv
// package of constants and types for the half-bridge fault state logic
// ****************************************************************
// Behaviour
// - drive sink, source, gentle-pulldown pins by state
// - gates follow commands in normal operation
// - sync fault pin low freezes both gates
// - fault shutdown pin low forces gates off
// - any monitored level change re-evaluates the state
// - after floating undervolt, top waits command rise
// - sync fault output releases after gentle turnoff
// - controller avoids release while sync fault low after power-up
// - controller never holds fault release permanently
// - controller holds release during supply power-up
// - bootstrap order: release, bottom pulse, drop
// - power-up pulses last at least minimum time
// - floating undervolt turns off top gate only
// - logic undervolt drives shutdown pin, not latched
// - gentle turnoff end latches fault, gates off
// - undervolt and shutdown ignored during gentle turnoff
// ****************************************************************
package hbf_pkg;
	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_PS      = 5000;
	localparam int GENTLE_TIME_NS     = 9250;
	localparam int GENTLE_CYCLES      = (GENTLE_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int DESAT_FILT_NS      = 1000;
	localparam int DESAT_FILT_CYCLES  = (DESAT_FILT_NS * 1000 + CLK_PERIOD_PS - 1)
	                                    / CLK_PERIOD_PS;
	localparam int BLANK_TIME_NS      = 3000;
	localparam int BLANK_CYCLES       = (BLANK_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
	                                    / CLK_PERIOD_PS;
	localparam int PWRUP_PULSE_NS     = 15000;
	localparam int PWRUP_PULSE_CYCLES = (PWRUP_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
	                                    / CLK_PERIOD_PS;
	localparam int CNT_W              = 16;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

	// ****************************************************************
	// gate, main state machine and power-up sequencer state codes
	// ****************************************************************
	typedef enum logic [1:0] {
		GATE_OFF    = 2'b00,
		GATE_ON     = 2'b01,
		GATE_GENTLE = 2'b10
	} hbf_gate_t;

	typedef enum logic [2:0] {
		ST_RUN    = 3'b000,
		ST_GENTLE = 3'b001,
		ST_FAULT  = 3'b010
	} hbf_state_t;

	typedef enum logic [2:0] {
		SEQ_IDLE   = 3'b000,
		SEQ_REL_UP = 3'b001,
		SEQ_BOT_UP = 3'b010,
		SEQ_BOT_DN = 3'b011,
		SEQ_REL_DN = 3'b100,
		SEQ_DONE   = 3'b101
	} hbf_seq_t;
endpackage

// File: logic/hbf_link_if.sv
// interface joining driver logic and system controller
`timescale 1ns/1ps
interface hbf_link_if;
	logic       top_cmd;
	logic       bottom_cmd;
	logic       fault_release_in;
	logic       sync_fault_drv_dev;
	logic       sync_fault_drv_ctl;
	logic       sync_fault_pin;
	logic       fault_shutdown_drv_dev;
	logic       fault_shutdown_drv_ctl;
	logic       fault_shutdown_pin;

	// open-drain wired-and of both ends
	assign sync_fault_pin     = ~(sync_fault_drv_dev | sync_fault_drv_ctl);
	assign fault_shutdown_pin = ~(fault_shutdown_drv_dev | fault_shutdown_drv_ctl);

	modport dev
	(
		input  top_cmd,
		input  bottom_cmd,
		input  fault_release_in,
		input  sync_fault_pin,
		input  fault_shutdown_pin,
		output sync_fault_drv_dev,
		output fault_shutdown_drv_dev
	);
	modport ctl
	(
		output top_cmd,
		output bottom_cmd,
		output fault_release_in,
		output sync_fault_drv_ctl,
		output fault_shutdown_drv_ctl,
		input  sync_fault_pin,
		input  fault_shutdown_pin
	);
endinterface

// File: logic/hbf_driver.sv
// gate driver fault and output state logic
`timescale 1ns/1ps
module hbf_driver
	import hbf_pkg::*;
#(
	parameter int GENTLE_CNT = GENTLE_CYCLES
)
(
	input  wire logic  core_clk_i,
	input  wire logic  rst_n_i,
	hbf_link_if.dev    link,
	input  wire logic  logic_supply_undervolt_i,
	input  wire logic  floating_supply_undervolt_i,
	input  wire logic  top_desat_sense_i,
	input  wire logic  bottom_desat_sense_i,
	output logic       top_source_o,
	output logic       top_source_oe_o,
	output logic       top_sink_o,
	output logic       top_sink_oe_o,
	output logic       top_pulldown_o,
	output logic       top_pulldown_oe_o,
	output logic       bottom_source_o,
	output logic       bottom_source_oe_o,
	output logic       bottom_sink_o,
	output logic       bottom_sink_oe_o,
	output logic       bottom_pulldown_o,
	output logic       bottom_pulldown_oe_o,
	output hbf_gate_t  top_gate_state_o,
	output hbf_gate_t  bottom_gate_state_o
);
	// ****************************************************************
	// state
	// ****************************************************************
	hbf_state_t        state_reg;
	hbf_gate_t         top_reg;
	hbf_gate_t         bot_reg;
	logic              top_wait_reg;
	logic              top_cmd_d_reg;
	logic [CNT_W-1:0]  gentle_cnt_reg;
	logic [CNT_W-1:0]  top_filt_reg;
	logic [CNT_W-1:0]  bot_filt_reg;
	logic [CNT_W-1:0]  top_blank_reg;
	logic [CNT_W-1:0]  bot_blank_reg;
	logic              top_desat;
	logic              bot_desat;
	logic              shutdown_in;
	logic              freeze_in;
	logic              both_cmd;
	hbf_gate_t         top_next;
	hbf_gate_t         bot_next;

	localparam logic [CNT_W-1:0] FILT_MAX  = CNT_W'(DESAT_FILT_CYCLES);
	localparam logic [CNT_W-1:0] BLANK_MAX = CNT_W'(BLANK_CYCLES);
	localparam logic [CNT_W-1:0] GEN_MAX   = CNT_W'(GENTLE_CNT);

	// own drive of shutdown pin is not an external shutdown request
	assign shutdown_in = ~link.fault_shutdown_pin & ~link.fault_shutdown_drv_dev;
	assign freeze_in   = ~link.sync_fault_pin & ~link.sync_fault_drv_dev;
	assign both_cmd    = link.top_cmd & link.bottom_cmd;

	// ****************************************************************
	// desat qualification: blanking after turn on, pulse filter
	// ****************************************************************
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i || top_reg != GATE_ON)
			top_blank_reg <= CNT_ZERO;
		else if (top_blank_reg != BLANK_MAX)
			top_blank_reg <= top_blank_reg + 16'h0001;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i || bot_reg != GATE_ON)
			bot_blank_reg <= CNT_ZERO;
		else if (bot_blank_reg != BLANK_MAX)
			bot_blank_reg <= bot_blank_reg + 16'h0001;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i || !top_desat_sense_i || top_blank_reg != BLANK_MAX)
			top_filt_reg <= CNT_ZERO;
		else if (top_filt_reg != FILT_MAX)
			top_filt_reg <= top_filt_reg + 16'h0001;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i || !bottom_desat_sense_i || bot_blank_reg != BLANK_MAX)
			bot_filt_reg <= CNT_ZERO;
		else if (bot_filt_reg != FILT_MAX)
			bot_filt_reg <= bot_filt_reg + 16'h0001;
	end

	assign top_desat = (top_filt_reg == FILT_MAX) && (top_reg == GATE_ON);
	assign bot_desat = (bot_filt_reg == FILT_MAX) && (bot_reg == GATE_ON);

	// ****************************************************************
	// top side rising edge wait after floating undervolt
	// ****************************************************************
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			top_cmd_d_reg <= 1'b0;
		else
			top_cmd_d_reg <= link.top_cmd;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			top_wait_reg <= 1'b0;
		else if (floating_supply_undervolt_i)
			top_wait_reg <= 1'b1;
		else if (link.top_cmd && !top_cmd_d_reg)
			top_wait_reg <= 1'b0;
	end

	// ****************************************************************
	// main state machine
	// ****************************************************************
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			state_reg <= ST_RUN;
		else
		begin
			case (state_reg)
				ST_RUN:
					if (!shutdown_in && !freeze_in && !logic_supply_undervolt_i
					    && (top_desat || bot_desat))
						state_reg <= ST_GENTLE;
				ST_GENTLE:
					if (gentle_cnt_reg == GEN_MAX)
						state_reg <= ST_FAULT;
				ST_FAULT:
					if (link.fault_release_in && !logic_supply_undervolt_i
					    && !floating_supply_undervolt_i)
						state_reg <= ST_RUN;
				default:
					state_reg <= ST_RUN;
			endcase
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i || state_reg != ST_GENTLE)
			gentle_cnt_reg <= CNT_ZERO;
		else if (gentle_cnt_reg != GEN_MAX)
			gentle_cnt_reg <= gentle_cnt_reg + 16'h0001;
	end

	// ****************************************************************
	// gate state selection
	// ****************************************************************
	always_comb
	begin
		top_next = top_reg;
		bot_next = bot_reg;
		case (state_reg)
			ST_GENTLE:
			begin
				// undervolt and shutdown masked here
				top_next = (top_reg == GATE_GENTLE) ? GATE_GENTLE : GATE_OFF;
				bot_next = (bot_reg == GATE_GENTLE) ? GATE_GENTLE : GATE_OFF;
			end
			ST_FAULT:
			begin
				top_next = GATE_OFF;
				bot_next = GATE_OFF;
			end
			default:
			begin
				// stay off until own pin drive is released
				if (shutdown_in || logic_supply_undervolt_i || link.fault_shutdown_drv_dev)
				begin
					top_next = GATE_OFF;
					bot_next = GATE_OFF;
				end
				else if (freeze_in)
				begin
					top_next = top_reg;
					bot_next = bot_reg;
				end
				else if (top_desat || bot_desat)
				begin
					top_next = top_desat ? GATE_GENTLE : GATE_OFF;
					bot_next = bot_desat ? GATE_GENTLE : GATE_OFF;
				end
				else if (both_cmd)
				begin
					top_next = GATE_OFF;
					bot_next = GATE_OFF;
				end
				else
				begin
					top_next = (link.top_cmd && !top_wait_reg
					            && !floating_supply_undervolt_i)
					           ? GATE_ON : GATE_OFF;
					bot_next = link.bottom_cmd ? GATE_ON : GATE_OFF;
				end
			end
		endcase
	end

	// any input level change re-evaluates the gates each cycle
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			top_reg <= GATE_OFF;
			bot_reg <= GATE_OFF;
		end
		else
		begin
			top_reg <= top_next;
			bot_reg <= bot_next;
		end
	end

	// ****************************************************************
	// open-drain status pins
	// ****************************************************************
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			link.sync_fault_drv_dev     <= 1'b0;
			link.fault_shutdown_drv_dev <= 1'b0;
		end
		else
		begin
			// releases itself when gentle turnoff ends
			link.sync_fault_drv_dev     <= (state_reg == ST_GENTLE)
			                               && (gentle_cnt_reg != GEN_MAX);
			link.fault_shutdown_drv_dev <= (state_reg == ST_GENTLE && gentle_cnt_reg == GEN_MAX)
			                               || (state_reg == ST_FAULT && !(link.fault_release_in
			                                   && !logic_supply_undervolt_i
			                                   && !floating_supply_undervolt_i))
			                               || (state_reg == ST_RUN
			                                   && logic_supply_undervolt_i);
		end
	end

	// ****************************************************************
	// output stage decode
	// ****************************************************************
	always_comb
	begin
		top_source_o      = 1'b1;
		top_source_oe_o   = (top_reg == GATE_ON);
		top_sink_o        = 1'b0;
		top_sink_oe_o     = (top_reg == GATE_OFF);
		top_pulldown_o    = 1'b0;
		top_pulldown_oe_o = (top_reg == GATE_GENTLE);
		bottom_source_o      = 1'b1;
		bottom_source_oe_o   = (bot_reg == GATE_ON);
		bottom_sink_o        = 1'b0;
		bottom_sink_oe_o     = (bot_reg == GATE_OFF);
		bottom_pulldown_o    = 1'b0;
		bottom_pulldown_oe_o = (bot_reg == GATE_GENTLE);
	end

	assign top_gate_state_o    = top_reg;
	assign bottom_gate_state_o = bot_reg;
endmodule // hbf_driver

// File: logic/hbf_controller.sv
// system controller end: power-up sequence and command pass-through
`timescale 1ns/1ps
module hbf_controller
	import hbf_pkg::*;
#(
	parameter int PULSE_CNT = PWRUP_PULSE_CYCLES
)
(
	input  wire logic  core_clk_i,
	input  wire logic  rst_n_i,
	hbf_link_if.ctl    link,
	input  wire logic  supplies_ok_i,
	input  wire logic  top_cmd_i,
	input  wire logic  bottom_cmd_i,
	input  wire logic  release_req_i,
	input  wire logic  shutdown_req_i,
	input  wire logic  freeze_req_i,
	output logic       ready_o,
	output logic       sync_fault_o,
	output logic       fault_o
);
	// ****************************************************************
	// power-up sequencer
	// ****************************************************************
	localparam logic [CNT_W-1:0] PULSE_MAX = CNT_W'(PULSE_CNT);

	hbf_seq_t          seq_reg;
	logic [CNT_W-1:0]  cnt_reg;
	logic              release_reg;
	logic              top_reg;
	logic              bot_reg;
	logic              rel_ok;

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			seq_reg <= SEQ_IDLE;
			cnt_reg <= CNT_ZERO;
		end
		else
		begin
			cnt_reg <= cnt_reg + 16'h0001;
			case (seq_reg)
				SEQ_IDLE:
				begin
					seq_reg <= SEQ_REL_UP;
					cnt_reg <= CNT_ZERO;
				end
				SEQ_REL_UP:
					if (supplies_ok_i)
					begin
						seq_reg <= SEQ_BOT_UP;
						cnt_reg <= CNT_ZERO;
					end
				SEQ_BOT_UP:
					if (cnt_reg >= PULSE_MAX)
					begin
						seq_reg <= SEQ_BOT_DN;
						cnt_reg <= CNT_ZERO;
					end
				SEQ_BOT_DN:
					if (cnt_reg >= PULSE_MAX)
						seq_reg <= SEQ_REL_DN;
				SEQ_REL_DN:
					seq_reg <= SEQ_DONE;
				SEQ_DONE:
					cnt_reg <= CNT_ZERO;
				default:
					seq_reg <= SEQ_IDLE;
			endcase
		end
	end

	// release one cycle pulse only, never while sync fault low
	assign rel_ok = release_req_i && link.sync_fault_pin && !release_reg;

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			release_reg <= 1'b0;
			top_reg     <= 1'b0;
			bot_reg     <= 1'b0;
		end
		else if (seq_reg != SEQ_DONE)
		begin
			release_reg <= (seq_reg != SEQ_IDLE) && (seq_reg != SEQ_REL_DN);
			top_reg     <= 1'b0;
			bot_reg     <= (seq_reg == SEQ_BOT_UP);
		end
		else
		begin
			release_reg <= rel_ok;
			top_reg     <= top_cmd_i;
			bot_reg     <= bottom_cmd_i;
		end
	end

	assign link.fault_release_in       = release_reg;
	assign link.top_cmd                = top_reg;
	assign link.bottom_cmd             = bot_reg;
	assign link.fault_shutdown_drv_ctl = shutdown_req_i;
	assign link.sync_fault_drv_ctl     = freeze_req_i;
	assign ready_o                     = (seq_reg == SEQ_DONE);
	assign sync_fault_o                = ~link.sync_fault_pin;
	assign fault_o                     = ~link.fault_shutdown_pin;
endmodule // hbf_controller

// File: tb/hbf_monitor.sv
// checker of link pins and gate states
`timescale 1ns/1ps
module hbf_monitor
	import hbf_pkg::*;
#(
	parameter int GENTLE_CNT = 8
)
(
	input  wire logic      core_clk_i,
	input  wire logic      rst_n_i,
	input  wire logic      top_cmd,
	input  wire logic      bottom_cmd,
	input  wire logic      fault_release_in,
	input  wire logic      sync_fault_pin,
	input  wire logic      fault_shutdown_pin,
	input  wire logic      sync_fault_drv_dev,
	input  wire logic      fault_shutdown_drv_dev,
	input  wire logic      logic_supply_undervolt_i,
	input  wire logic      floating_supply_undervolt_i,
	input  wire logic      bottom_desat_sense_i,
	input  wire hbf_gate_t top_gate_state_o,
	input  wire hbf_gate_t bottom_gate_state_o
);
	// ****************************************************************
	// assertions
	// ****************************************************************
	localparam int SYNC_MAX = GENTLE_CNT + 4;
	logic no_gentle;
	assign no_gentle = (top_gate_state_o != GATE_GENTLE) && (bottom_gate_state_o != GATE_GENTLE);

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_bottom_follow;
		bottom_cmd && !top_cmd && sync_fault_pin && fault_shutdown_pin && !logic_supply_undervolt_i
			&& !bottom_desat_sense_i && no_gentle |=> bottom_gate_state_o == GATE_ON;
	endproperty
	a_bottom_follow: assert property (p_bottom_follow)
		else $error("bottom gate not following command");
	property p_shutdown;
		!fault_shutdown_pin && no_gentle |=> top_gate_state_o == GATE_OFF
			&& bottom_gate_state_o == GATE_OFF;
	endproperty
	a_shutdown: assert property (p_shutdown)
		else $error("gate on while shutdown pin low");
	property p_freeze;
		!sync_fault_pin && fault_shutdown_pin && !logic_supply_undervolt_i && no_gentle
			|=> $stable(top_gate_state_o) && $stable(bottom_gate_state_o);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("gate moved while frozen");
	property p_sync_len;
		$rose(sync_fault_drv_dev) |-> ##[1:SYNC_MAX] $fell(sync_fault_drv_dev);
	endproperty
	a_sync_len: assert property (p_sync_len)
		else $error("sync fault drive not released");
	property p_fault_on_end;
		$fell(sync_fault_drv_dev) |-> $rose(fault_shutdown_drv_dev);
	endproperty
	a_fault_on_end: assert property (p_fault_on_end)
		else $error("no fault drive at end of gentle turnoff");
	property p_latched;
		fault_shutdown_drv_dev && !fault_release_in && !logic_supply_undervolt_i
			&& !$past(logic_supply_undervolt_i) |=> fault_shutdown_drv_dev;
	endproperty
	a_latched: assert property (p_latched)
		else $error("fault drive dropped without release");
	property p_clear;
		fault_shutdown_drv_dev && fault_release_in && !logic_supply_undervolt_i
			&& !floating_supply_undervolt_i && no_gentle |=> !fault_shutdown_drv_dev;
	endproperty
	a_clear: assert property (p_clear)
		else $error("fault drive kept after release");
	property p_uv_fault;
		logic_supply_undervolt_i && no_gentle |=> fault_shutdown_drv_dev
			&& top_gate_state_o == GATE_OFF;
	endproperty
	a_uv_fault: assert property (p_uv_fault)
		else $error("logic undervolt not reported");
	property p_float_top;
		floating_supply_undervolt_i && sync_fault_pin && no_gentle |=> top_gate_state_o != GATE_ON;
	endproperty
	a_float_top: assert property (p_float_top)
		else $error("top gate on during floating undervolt");
	property p_ctl_pulse;
		$rose(bottom_cmd) && fault_release_in |-> bottom_cmd [*5];
	endproperty
	a_ctl_pulse: assert property (p_ctl_pulse)
		else $error("bottom charge pulse too short");
endmodule // hbf_monitor

// File: tb/tb.sv
// self-checking bench joining driver and controller ends
`timescale 1ns/1ps
module tb
	import hbf_pkg::*;
;
	localparam int PULSE = 4;
	localparam int GENT  = 8;
	logic      core_clk_i = 1'b0;
	logic      rst_n_i    = 1'b0;
	logic      sup_ok, top_c, bot_c, rel_r, sd_r, frz_r, luv, fuv, tds, bds;
	logic      ready, syf, flt, t_src_oe, t_snk_oe, b_snk_oe, b_pd_oe;
	logic      t_src, t_snk, t_pd, t_pd_oe, b_src, b_src_oe, b_snk, b_pd;
	hbf_gate_t top_gs, bot_gs;
	int        num_errors = 0;
	int        checked    = 0;

	always #2.5 core_clk_i = ~core_clk_i;

	hbf_link_if lnk();
	hbf_driver #(.GENTLE_CNT(GENT)) i_hbf_driver (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.link(lnk), .logic_supply_undervolt_i(luv), .floating_supply_undervolt_i(fuv),
		.top_desat_sense_i(tds), .bottom_desat_sense_i(bds), .top_source_o(t_src),
		.top_source_oe_o(t_src_oe), .top_sink_o(t_snk), .top_sink_oe_o(t_snk_oe),
		.top_pulldown_o(t_pd), .top_pulldown_oe_o(t_pd_oe), .bottom_source_o(b_src),
		.bottom_source_oe_o(b_src_oe), .bottom_sink_o(b_snk),
		.bottom_sink_oe_o(b_snk_oe), .bottom_pulldown_o(b_pd), .bottom_pulldown_oe_o(b_pd_oe),
		.top_gate_state_o(top_gs), .bottom_gate_state_o(bot_gs));
	hbf_controller #(.PULSE_CNT(PULSE)) i_hbf_controller (.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i), .link(lnk), .supplies_ok_i(sup_ok), .top_cmd_i(top_c),
		.bottom_cmd_i(bot_c), .release_req_i(rel_r), .shutdown_req_i(sd_r), .freeze_req_i(frz_r),
		.ready_o(ready), .sync_fault_o(syf), .fault_o(flt));
	hbf_monitor #(.GENTLE_CNT(GENT)) i_hbf_monitor (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.top_cmd(lnk.top_cmd), .bottom_cmd(lnk.bottom_cmd), .fault_release_in(lnk.fault_release_in),
		.sync_fault_pin(lnk.sync_fault_pin), .fault_shutdown_pin(lnk.fault_shutdown_pin),
		.sync_fault_drv_dev(lnk.sync_fault_drv_dev),
		.fault_shutdown_drv_dev(lnk.fault_shutdown_drv_dev), .logic_supply_undervolt_i(luv),
		.floating_supply_undervolt_i(fuv), .bottom_desat_sense_i(bds),
		.top_gate_state_o(top_gs), .bottom_gate_state_o(bot_gs));

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic step(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask
	task automatic chk_bit(input logic act, input logic exp);
		checked++;
		if (act !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, act, exp);
		end
	endtask
	task automatic chk_gate(input hbf_gate_t act, input hbf_gate_t exp);
		checked++;
		if (act !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, act, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic expire;
		num_errors++;
		stop_test();
	endtask
	task automatic cmd(input logic t, input logic b);
		top_c = t;
		bot_c = b;
		step(3);
	endtask

	// ****************************************************************
	// sequence
	// ****************************************************************
	initial
	begin
		int i;
		int n;
		int bad;
		{sup_ok, top_c, bot_c, rel_r, sd_r, frz_r, luv, fuv, tds, bds} = 10'h000;
		n = 0;
		bad = 0;
		step(2);
		rst_n_i = 1'b1;
		step(5);
		chk_bit(lnk.fault_release_in, 1'b1);
		chk_bit(flt, 1'b0);
		sup_ok = 1'b1;
		for (i = 0; i < 100 && ready !== 1'b1; i++)
		begin
			step(1);
			if (lnk.bottom_cmd === 1'b1)
				n++;
			if (lnk.bottom_cmd === 1'b1 && lnk.fault_release_in !== 1'b1)
				bad++;
		end
		if (ready !== 1'b1)
			expire();
		chk_bit(n == PULSE + 1, 1'b1);
		chk_bit(bad == 0, 1'b1);
		chk_bit(lnk.fault_release_in, 1'b0);
		cmd(1'b1, 1'b0);
		chk_gate(top_gs, GATE_ON);
		chk_bit(t_src_oe, 1'b1);
		chk_bit(t_snk_oe, 1'b0);
		chk_bit(t_src, 1'b1);
		chk_bit(t_pd_oe, 1'b0);
		cmd(1'b1, 1'b1);
		chk_gate(top_gs, GATE_OFF);
		chk_gate(bot_gs, GATE_OFF);
		chk_bit(b_snk_oe, 1'b1);
		chk_bit(b_snk, 1'b0);
		chk_bit(t_snk, 1'b0);
		cmd(1'b1, 1'b0);
		frz_r = 1'b1;
		cmd(1'b0, 1'b1);
		chk_gate(top_gs, GATE_ON);
		chk_gate(bot_gs, GATE_OFF);
		frz_r = 1'b0;
		step(3);
		chk_gate(bot_gs, GATE_ON);
		chk_bit(b_src_oe, 1'b1);
		chk_bit(b_src, 1'b1);
		sd_r = 1'b1;
		step(3);
		chk_gate(bot_gs, GATE_OFF);
		cmd(1'b1, 1'b0);
		chk_gate(top_gs, GATE_OFF);
		sd_r = 1'b0;
		step(3);
		fuv = 1'b1;
		step(3);
		chk_gate(top_gs, GATE_OFF);
		cmd(1'b0, 1'b1);
		chk_gate(bot_gs, GATE_ON);
		chk_bit(flt, 1'b0);
		cmd(1'b1, 1'b0);
		fuv = 1'b0;
		step(3);
		chk_gate(top_gs, GATE_OFF);
		cmd(1'b0, 1'b0);
		cmd(1'b1, 1'b0);
		chk_gate(top_gs, GATE_ON);
		luv = 1'b1;
		step(3);
		chk_bit(flt, 1'b1);
		chk_gate(top_gs, GATE_OFF);
		luv = 1'b0;
		step(3);
		chk_bit(flt, 1'b0);
		cmd(1'b0, 1'b1);
		bds = 1'b1;
		for (i = 0; i < 1000 && bot_gs !== GATE_GENTLE; i++)
			step(1);
		if (bot_gs !== GATE_GENTLE)
			expire();
		chk_bit(b_pd_oe, 1'b1);
		chk_bit(b_snk_oe, 1'b0);
		chk_bit(b_pd, 1'b0);
		chk_bit(b_src_oe, 1'b0);
		step(2);
		chk_bit(syf, 1'b1);
		sd_r = 1'b1;
		rel_r = 1'b1;
		step(2);
		chk_gate(bot_gs, GATE_GENTLE);
		chk_bit(lnk.fault_release_in, 1'b0);
		sd_r = 1'b0;
		rel_r = 1'b0;
		for (i = 0; i < 50 && syf === 1'b1; i++)
			step(1);
		if (syf !== 1'b0)
			expire();
		chk_bit(syf, 1'b0);
		chk_bit(flt, 1'b1);
		step(3);
		bds = 1'b0;
		step(3);
		chk_gate(bot_gs, GATE_OFF);
		chk_gate(top_gs, GATE_OFF);
		rel_r = 1'b1;
		step(2);
		chk_bit(lnk.fault_release_in, 1'b0);
		rel_r = 1'b0;
		step(3);
		chk_bit(flt, 1'b0);
		chk_gate(bot_gs, GATE_ON);
		cmd(1'b1, 1'b0);
		tds = 1'b1;
		for (i = 0; i < 1000 && top_gs !== GATE_GENTLE; i++)
			step(1);
		if (top_gs !== GATE_GENTLE)
			expire();
		chk_gate(bot_gs, GATE_OFF);
		chk_bit(t_pd_oe, 1'b1);
		chk_bit(t_pd, 1'b0);
		for (i = 0; i < 50 && flt !== 1'b1; i++)
			step(1);
		if (flt !== 1'b1)
			expire();
		chk_bit(syf, 1'b0);
		step(2);
		chk_gate(top_gs, GATE_OFF);
		tds = 1'b0;
		rel_r = 1'b1;
		step(2);
		rel_r = 1'b0;
		step(3);
		chk_bit(flt, 1'b0);
		chk_gate(top_gs, GATE_ON);
		stop_test();
	end
endmodule // tb
